// file: hdl/pin_sync.sv
// Two-stage synchroniser for inputs from outside the clock domain
`timescale 1ns/10ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            meta <= '0;
            level <= '0;
        end else begin
            meta <= pin_in;
            level <= meta;
        end
    end
endmodule : pin_sync

// file: hdl/serial_lane.sv
// Byte shifter for one serial port: MSB first out, MSB first in
`timescale 1ns/10ps
module serial_lane #(
    parameter int WIDTH = 8
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic load,
    input wire logic shift,
    input wire logic sample,
    input wire logic [WIDTH-1:0] tx_byte,
    input wire logic rx_bit,
    output logic tx_bit,
    output logic [WIDTH-1:0] rx_byte
);
    logic [WIDTH-1:0] tx_sh;
    logic [WIDTH-1:0] rx_sh;

    always_ff @(posedge sys_clk) begin
        if (rst) tx_sh <= '1;
        else if (load) tx_sh <= tx_byte;
        else if (shift) tx_sh <= {tx_sh[WIDTH-2:0], 1'b1};
    end

    always_ff @(posedge sys_clk) begin
        if (rst) rx_sh <= '0;
        else if (sample) rx_sh <= {rx_sh[WIDTH-2:0], rx_bit};
    end

    assign tx_bit = tx_sh[WIDTH-1];
    assign rx_byte = rx_sh;
endmodule : serial_lane

// file: hdl/tdm_port_channel_mapper.sv
// System-side serial ports: channel map, tristate, chain pulse, C decode
//
// Contract
// - Network port frame: 32 eight-bit channels
// - Dual: C,D on control port, B on voice
// - Dual slow rate: voice channel 0 is B1
// - Dual fast rate: channels 0,16 carry B1,B2
// - Single: all channels on voice port only
// - Single slow: D ch0, C ch1, B1 ch2
// - Single fast: B2 added in channel 3
// - Modem: both ports continuous at line rate
// - Unassigned channel times leave outputs high impedance
// - Forwarded pulse marks next device's channel time
// - Chain holds at most sixteen devices
// - Control port active only in dual and modem operation
// - C then D half a frame later
// - Mode pins swap C and D byte order
// - D passes transparently, network mode only
// - Slow rate: only D0 reaches the line
// - Fast rate: D0 and D1 reach line
// - D-in-B1 bit: whole D byte in B1
// - C carries control in, status out
// - C select 00 control, 10 diagnostic
// - Dual: D ch0 C ch16 or reverse
// - Mode 7 holds both outputs high impedance
// - Control bits 4-7 ones: default mode
`timescale 1ns/10ps
module tdm_port_channel_mapper (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic bus_bit_clk,
    input wire logic system_frame_pulse_n,
    input wire logic [2:0] mode_select,
    input wire logic voice_port_serial_in,
    input wire logic ctl_port_serial_in,
    input wire tdm_mapper_pkg::line_bytes_type line_rx,
    input wire logic [7:0] status_byte,
    input wire logic modem_line_bit,
    input wire logic modem_line_ctl_bit,
    output logic voice_port_serial_out,
    output logic voice_port_serial_oe,
    output logic ctl_port_serial_out,
    output logic ctl_port_serial_oe,
    output logic forward_frame_pulse_n,
    output tdm_mapper_pkg::line_bytes_type line_tx,
    output logic line_tx_valid,
    output logic [7:0] line_control_byte,
    output logic [7:0] diag_byte,
    output logic modem_bus_bit,
    output logic modem_bus_ctl_bit,
    output logic modem_bus_valid
);
    import tdm_mapper_pkg::*;

    // ------------------------------------------------------------------
    // Pin synchronisation and bus clock edges
    // ------------------------------------------------------------------
    logic [6:0] sync_level;
    logic clk_s;
    logic frame_s;
    logic voice_s;
    logic ctl_s;
    logic [2:0] mode_s;
    logic clk_prev;
    logic rise;
    logic fall;
    logic rise_d;

    pin_sync #(.WIDTH(7)) u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .pin_in({bus_bit_clk, system_frame_pulse_n, voice_port_serial_in,
                 ctl_port_serial_in, mode_select}),
        .level(sync_level)
    );

    assign {clk_s, frame_s, voice_s, ctl_s, mode_s} = sync_level;
    assign rise = clk_s & ~clk_prev;
    assign fall = ~clk_s & clk_prev;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            clk_prev <= 1'b0;
            rise_d <= 1'b0;
        end else begin
            clk_prev <= clk_s;
            rise_d <= rise;
        end
    end

    // ------------------------------------------------------------------
    // Mode and frame position
    // ------------------------------------------------------------------
    mode_cfg_type cfg;
    logic modem;
    logic fast;
    logic d_in_b1_slot;
    logic frame_seen;
    logic [CNT_W-1:0] bit_cnt;
    logic [CNT_W-1:0] next_cnt;
    logic [CH_W-1:0] next_ch;
    logic [CNT_W-1:0] fwd_cnt;

    assign cfg = decode_mode(mode_s);
    assign modem = ~cfg.network;
    assign fast = line_control_byte[BRS_BIT];
    assign d_in_b1_slot = line_control_byte[D_IN_B1_SLOT_BIT];
    assign next_cnt = frame_seen ? '0 : CNT_W'(bit_cnt + CNT_ONE);
    assign next_ch = next_cnt[CNT_W-1:BIT_W];
    assign fwd_cnt = CNT_W'({span_chans(cfg, fast), FIRST_BIT} - CNT_ONE);

    always_ff @(posedge sys_clk) begin
        if (rst) frame_seen <= 1'b0;
        else if (fall) frame_seen <= ~frame_s;
        else if (rise) frame_seen <= 1'b0;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) bit_cnt <= FRAME_LAST;
        else if (rise) bit_cnt <= next_cnt;
    end

    // ------------------------------------------------------------------
    // Channel map and lanes
    // ------------------------------------------------------------------
    slot_type vslot_next;
    slot_type cslot_next;
    slot_type cur_vslot;
    slot_type cur_cslot;
    logic load;
    logic shift;
    logic voice_tx_bit;
    logic ctl_tx_bit;
    logic [7:0] voice_rx_byte;
    logic [7:0] ctl_rx_byte;
    logic [7:0] d_to_bus;

    assign vslot_next = voice_slot(cfg, fast, next_ch);
    assign cslot_next = ctl_slot(cfg, next_ch);
    assign load = rise && next_cnt[BIT_W-1:0] == FIRST_BIT;
    assign shift = rise && !load;
    assign d_to_bus = d_in_b1_slot ? line_rx.b1
                    : line_rx.d | (fast ? D_MASK_FAST : D_MASK_SLOW);

    function automatic logic [7:0] bus_byte(input slot_type s);
        case (s)
            SLOT_B1: return line_rx.b1;
            SLOT_B2: return line_rx.b2;
            SLOT_C: return status_byte;
            SLOT_D: return d_to_bus;
            default: return BYTE_IDLE;
        endcase
    endfunction : bus_byte

    serial_lane #(.WIDTH(BITS_PER_CHAN)) u_voice_lane (
        .sys_clk(sys_clk),
        .rst(rst),
        .load(load),
        .shift(shift),
        .sample(fall),
        .tx_byte(bus_byte(vslot_next)),
        .rx_bit(voice_s),
        .tx_bit(voice_tx_bit),
        .rx_byte(voice_rx_byte)
    );

    serial_lane #(.WIDTH(BITS_PER_CHAN)) u_ctl_lane (
        .sys_clk(sys_clk),
        .rst(rst),
        .load(load),
        .shift(shift),
        .sample(fall),
        .tx_byte(bus_byte(cslot_next)),
        .rx_bit(ctl_s),
        .tx_bit(ctl_tx_bit),
        .rx_byte(ctl_rx_byte)
    );

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cur_vslot <= SLOT_NONE;
            cur_cslot <= SLOT_NONE;
        end else if (rise) begin
            cur_vslot <= modem ? SLOT_NONE : vslot_next;
            cur_cslot <= modem ? SLOT_NONE : cslot_next;
        end
    end

    // ------------------------------------------------------------------
    // Serial outputs, enables and forwarded frame pulse
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            voice_port_serial_out <= 1'b1;
            voice_port_serial_oe <= 1'b0;
            ctl_port_serial_out <= 1'b1;
            ctl_port_serial_oe <= 1'b0;
        end else if (rise_d) begin
            voice_port_serial_out <= modem ? modem_line_bit : voice_tx_bit;
            ctl_port_serial_out <= modem ? modem_line_ctl_bit : ctl_tx_bit;
            voice_port_serial_oe <= !cfg.tristate
                && (modem || cur_vslot != SLOT_NONE);
            ctl_port_serial_oe <= !cfg.tristate && !cfg.single
                && (modem || cur_cslot != SLOT_NONE);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) forward_frame_pulse_n <= 1'b1;
        else if (rise_d) forward_frame_pulse_n <= bit_cnt != fwd_cnt;
    end

    // ------------------------------------------------------------------
    // Received bytes: line bytes and C channel
    // ------------------------------------------------------------------
    logic rx_done;
    logic frame_done;
    logic c_done;
    logic [7:0] c_byte;
    logic [7:0] acc_b1;
    logic [7:0] acc_b2;
    logic [7:0] acc_d;

    always_ff @(posedge sys_clk) begin
        if (rst) rx_done <= 1'b0;
        else rx_done <= fall && bit_cnt[BIT_W-1:0] == LAST_BIT;
    end

    assign frame_done = rx_done && bit_cnt == FRAME_LAST;
    assign c_done = rx_done
        && (cfg.single ? cur_vslot == SLOT_C : cur_cslot == SLOT_C);
    assign c_byte = cfg.single ? voice_rx_byte : ctl_rx_byte;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            acc_b1 <= BYTE_IDLE;
            acc_b2 <= BYTE_IDLE;
            acc_d <= BYTE_IDLE;
        end else if (rx_done) begin
            if (cur_vslot == SLOT_B1) acc_b1 <= voice_rx_byte;
            if (cur_vslot == SLOT_B2) acc_b2 <= voice_rx_byte;
            if (cur_vslot == SLOT_D) acc_d <= voice_rx_byte;
            if (cur_cslot == SLOT_D) acc_d <= ctl_rx_byte;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            line_tx <= '{b1: BYTE_IDLE, b2: BYTE_IDLE, d: BYTE_IDLE};
            line_tx_valid <= 1'b0;
        end else begin
            line_tx_valid <= frame_done && cfg.network;
            if (frame_done) begin
                line_tx.b1 <= d_in_b1_slot ? acc_d : acc_b1;
                line_tx.b2 <= acc_b2;
                line_tx.d <= d_in_b1_slot ? BYTE_IDLE
                    : acc_d | (fast ? D_MASK_FAST : D_MASK_SLOW);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            line_control_byte <= CTRL_RESET;
            diag_byte <= DIAG_RESET;
        end else if (c_done) begin
            if (c_byte[TX_HOUSEKEEPING_BIT_BIT:D_IN_B1_SLOT_BIT] == DEFAULT_KEY) begin
                line_control_byte <= c_byte[BRS_BIT] ? CTRL_DEFAULT_FAST
                                                     : CTRL_DEFAULT_SLOW;
                diag_byte <= DIAG_DEFAULT;
            end else if ({c_byte[SEL2_BIT], c_byte[SEL1_BIT]} == SEL_CONTROL)
            begin
                line_control_byte <= c_byte;
            end else if ({c_byte[SEL2_BIT], c_byte[SEL1_BIT]} == SEL_DIAG)
            begin
                diag_byte <= c_byte;
            end
        end
    end

    // ------------------------------------------------------------------
    // Modem streams
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            modem_bus_bit <= 1'b1;
            modem_bus_ctl_bit <= 1'b1;
            modem_bus_valid <= 1'b0;
        end else begin
            modem_bus_valid <= fall && modem;
            if (fall) begin
                modem_bus_bit <= voice_s;
                modem_bus_ctl_bit <= ctl_s;
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    tristate_hold_a: assert property (
        rise_d && cfg.tristate |=> !voice_port_serial_oe && !ctl_port_serial_oe)
        else $error("outputs driven in tristate mode");
    single_ctl_off_a: assert property (
        rise_d && cfg.single |=> !ctl_port_serial_oe)
        else $error("control port driven in single port operation");
    idle_slot_hiz_a: assert property (
        rise_d && cfg.network && cur_vslot == SLOT_NONE
        |=> !voice_port_serial_oe)
        else $error("voice port driven in unassigned channel");
    b1_slot_a: assert property (
        rise && cfg.network && !cfg.single && !cfg.tristate
        && next_ch == CH_ZERO |=> ##2 voice_port_serial_oe)
        else $error("channel 0 not driven in dual operation");
    b2_slot_a: assert property (
        rise && cfg.network && !cfg.single && !cfg.tristate
        && next_ch == CH_HALF |=> ##2 voice_port_serial_oe == $past(fast, 3))
        else $error("channel 16 drive does not follow line rate");
    fwd_pulse_a: assert property (
        $fell(forward_frame_pulse_n) |-> bit_cnt == fwd_cnt
        ##1 !forward_frame_pulse_n)
        else $error("forwarded pulse at wrong channel time");
    ctrl_write_a: assert property (
        c_done && c_byte[TX_HOUSEKEEPING_BIT_BIT:D_IN_B1_SLOT_BIT] != DEFAULT_KEY
        && {c_byte[SEL2_BIT], c_byte[SEL1_BIT]} == SEL_CONTROL
        |=> line_control_byte == $past(c_byte))
        else $error("control byte not written from C channel");
    default_mode_a: assert property (
        c_done && c_byte[TX_HOUSEKEEPING_BIT_BIT:D_IN_B1_SLOT_BIT] == DEFAULT_KEY
        |=> diag_byte == DIAG_DEFAULT && line_control_byte
        == ($past(c_byte[BRS_BIT]) ? CTRL_DEFAULT_FAST : CTRL_DEFAULT_SLOW))
        else $error("default mode not entered");
    d_mask_a: assert property (
        line_tx_valid && !fast && !d_in_b1_slot |-> line_tx.d[7:1] == 7'h7f)
        else $error("slow rate passed more than D0");
    frame_align_a: assert property (
        rise && frame_seen |=> bit_cnt == '0)
        else $error("frame pulse did not realign the count");

    single_frame_c: cover property (line_tx_valid && cfg.single);
    default_write_c: cover property (
        c_done && c_byte[TX_HOUSEKEEPING_BIT_BIT:D_IN_B1_SLOT_BIT] == DEFAULT_KEY);
    modem_bit_c: cover property (modem_bus_valid);
    d_in_b1_slot_frame_c: cover property (line_tx_valid && d_in_b1_slot);
endmodule : tdm_port_channel_mapper

// file: inc/tdm_mapper_pkg.sv
// Constants, types and channel map shared by the port channel mapper
package tdm_mapper_pkg;

    // ------------------------------------------------------------------
    // Frame geometry
    // ------------------------------------------------------------------
    localparam int BUS_RATE_KBPS = 2048;
    localparam int CHANS_PER_FRAME = 32;
    localparam int BITS_PER_CHAN = 8;
    localparam int CNT_W = 8;
    localparam int BIT_W = 3;
    localparam int CH_W = 5;
    localparam int MAX_CHAIN = 16;
    localparam logic [BIT_W-1:0] FIRST_BIT = 3'h0;
    localparam logic [BIT_W-1:0] LAST_BIT = 3'h7;
    localparam logic [CNT_W-1:0] FRAME_LAST = 8'hff;
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
    localparam logic [CH_W-1:0] CH_ZERO = 5'h00;
    localparam logic [CH_W-1:0] CH_ONE = 5'h01;
    localparam logic [CH_W-1:0] CH_TWO = 5'h02;
    localparam logic [CH_W-1:0] CH_THREE = 5'h03;
    localparam logic [CH_W-1:0] CH_HALF = 5'h10;
    localparam logic [CH_W-1:0] DUAL_SPAN = 5'h01;
    localparam logic [CH_W-1:0] SINGLE_SLOW_SPAN = 5'h03;
    localparam logic [CH_W-1:0] SINGLE_FAST_SPAN = 5'h04;

    // ------------------------------------------------------------------
    // Control byte layout and values
    // ------------------------------------------------------------------
    localparam int SEL1_BIT = 0;
    localparam int SEL2_BIT = 1;
    localparam int DRR_BIT = 2;
    localparam int BRS_BIT = 3;
    localparam int D_IN_B1_SLOT_BIT = 4;
    localparam int PRECURSOR_SHAPING_ENABLE_BIT = 5;
    localparam int FAST_CONVERGE_BIT = 6;
    localparam int TX_HOUSEKEEPING_BIT_BIT = 7;
    localparam logic [1:0] SEL_CONTROL = 2'h0;
    localparam logic [1:0] SEL_DIAG = 2'h2;
    localparam logic [3:0] DEFAULT_KEY = 4'hf;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] DIAG_RESET = 8'h00;
    localparam logic [7:0] CTRL_DEFAULT_SLOW = 8'h00;
    localparam logic [7:0] CTRL_DEFAULT_FAST = 8'h08;
    localparam logic [7:0] DIAG_DEFAULT = 8'h02;
    localparam logic [7:0] D_MASK_SLOW = 8'hfe;
    localparam logic [7:0] D_MASK_FAST = 8'hfc;
    localparam logic [7:0] BYTE_IDLE = 8'hff;
    localparam logic [2:0] MODE_TRISTATE = 3'h7;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {SLOT_NONE, SLOT_B1, SLOT_B2, SLOT_C, SLOT_D}
        slot_type;

    typedef struct packed {
        logic network;
        logic single;
        logic d_first;
        logic tristate;
    } mode_cfg_type;

    typedef struct packed {
        logic [7:0] b1;
        logic [7:0] b2;
        logic [7:0] d;
    } line_bytes_type;

    // ------------------------------------------------------------------
    // Mode pins and channel map
    // ------------------------------------------------------------------
    function automatic mode_cfg_type decode_mode(input logic [2:0] m);
        mode_cfg_type c;
        c = '{network: 1'b1, single: 1'b0, d_first: 1'b0, tristate: 1'b0};
        case (m)
            3'h1, 3'h5: c.network = 1'b0;
            3'h2: c.d_first = 1'b1;
            3'h3, 3'h6: c.single = 1'b1;
            MODE_TRISTATE: c.tristate = 1'b1;
            default: c.d_first = 1'b0;
        endcase
        return c;
    endfunction : decode_mode

    function automatic slot_type voice_slot(input mode_cfg_type c,
                                            input logic fast,
                                            input logic [CH_W-1:0] ch);
        slot_type s;
        s = SLOT_NONE;
        if (c.single) begin
            if (ch == CH_ZERO) s = SLOT_D;
            else if (ch == CH_ONE) s = SLOT_C;
            else if (ch == CH_TWO) s = SLOT_B1;
            else if (ch == CH_THREE && fast) s = SLOT_B2;
        end else begin
            if (ch == CH_ZERO) s = SLOT_B1;
            else if (ch == CH_HALF && fast) s = SLOT_B2;
        end
        return s;
    endfunction : voice_slot

    function automatic slot_type ctl_slot(input mode_cfg_type c,
                                          input logic [CH_W-1:0] ch);
        slot_type s;
        s = SLOT_NONE;
        if (!c.single) begin
            if (ch == CH_ZERO) s = c.d_first ? SLOT_D : SLOT_C;
            else if (ch == CH_HALF) s = c.d_first ? SLOT_C : SLOT_D;
        end
        return s;
    endfunction : ctl_slot

    function automatic logic [CH_W-1:0] span_chans(input mode_cfg_type c,
                                                   input logic fast);
        if (!c.single) return DUAL_SPAN;
        return fast ? SINGLE_FAST_SPAN : SINGLE_SLOW_SPAN;
    endfunction : span_chans

endpackage : tdm_mapper_pkg

// file: verif/tdm_bus_partner.sv
// Bus-side partner: frames both serial ports and records the outputs
`timescale 1ns/10ps
module tdm_bus_partner (
    input wire logic sys_clk,
    input wire logic [255:0] voice_frame,
    input wire logic [255:0] ctl_frame,
    input wire logic voice_port_serial_out,
    input wire logic voice_port_serial_oe,
    input wire logic ctl_port_serial_out,
    input wire logic ctl_port_serial_oe,
    input wire logic forward_frame_pulse_n,
    output logic bus_bit_clk,
    output logic system_frame_pulse_n,
    output logic voice_port_serial_in,
    output logic ctl_port_serial_in,
    output logic [255:0] voice_cap,
    output logic [255:0] ctl_cap,
    output logic [255:0] fwd_cap,
    output logic frame_done
);
    logic [4:0] phase;
    logic [7:0] bit_num;
    logic [7:0] nxt;
    logic v_bus;
    logic c_bus;
    assign nxt = bit_num + 8'h01;
    // Released outputs read as floating, never as the last value
    assign v_bus = voice_port_serial_oe ? voice_port_serial_out : 1'bz;
    assign c_bus = ctl_port_serial_oe ? ctl_port_serial_out : 1'bz;
    initial begin
        {phase, bus_bit_clk, frame_done} = '0;
        {bit_num, system_frame_pulse_n} = '1;
        {voice_port_serial_in, ctl_port_serial_in} = 2'h3;
    end
    // ----
    // Bit period of 20 cycles: drive on rise, sample on fall
    // ----
    always @(posedge sys_clk) begin
        phase <= (phase == 5'h13) ? 5'h00 : phase + 5'h01;
        frame_done <= 1'b0;
        if (phase == 5'h00) begin
            bus_bit_clk <= 1'b1;
            bit_num <= nxt;
            system_frame_pulse_n <= (nxt != 8'hff);
            voice_port_serial_in <= voice_frame[~nxt];
            ctl_port_serial_in <= ctl_frame[~nxt];
        end else if (phase == 5'h0a) begin
            bus_bit_clk <= 1'b0;
            voice_cap[~bit_num] <= v_bus;
            ctl_cap[~bit_num] <= c_bus;
            fwd_cap[~bit_num] <= forward_frame_pulse_n;
            frame_done <= (bit_num == 8'hff);
        end
    end
endmodule : tdm_bus_partner

// file: verif/tdm_port_channel_mapper_test.sv
// Self-checking bench: bus partner, byte model and comparisons
`timescale 1ns/10ps
module tdm_port_channel_mapper_test;
    import tdm_mapper_pkg::*;
    logic sys_clk, rst, bus_bit_clk, system_frame_pulse_n, frame_done;
    logic [2:0] mode_select;
    logic voice_port_serial_in, ctl_port_serial_in;
    logic voice_port_serial_out, voice_port_serial_oe;
    logic ctl_port_serial_out, ctl_port_serial_oe, forward_frame_pulse_n;
    logic modem_line_bit, modem_line_ctl_bit, line_tx_valid;
    logic modem_bus_bit, modem_bus_ctl_bit, modem_bus_valid;
    logic [7:0] status_byte, line_control_byte, diag_byte;
    line_bytes_type line_rx, line_tx;
    logic [255:0] voice_frame, ctl_frame, voice_cap, ctl_cap, fwd_cap;
    logic [15:0] lfsr;
    logic [7:0] exp_ctrl, exp_diag;
    int n_fail, num_checks, cycles;

    tdm_port_channel_mapper u_dut (.sys_clk, .rst, .bus_bit_clk,
        .system_frame_pulse_n, .mode_select, .voice_port_serial_in,
        .ctl_port_serial_in, .line_rx, .status_byte, .modem_line_bit,
        .modem_line_ctl_bit, .voice_port_serial_out, .voice_port_serial_oe,
        .ctl_port_serial_out, .ctl_port_serial_oe, .forward_frame_pulse_n,
        .line_tx, .line_tx_valid, .line_control_byte, .diag_byte,
        .modem_bus_bit, .modem_bus_ctl_bit, .modem_bus_valid);
    tdm_bus_partner u_partner (.sys_clk, .voice_frame, .ctl_frame,
        .voice_port_serial_out, .voice_port_serial_oe, .ctl_port_serial_out,
        .ctl_port_serial_oe, .forward_frame_pulse_n, .bus_bit_clk,
        .system_frame_pulse_n, .voice_port_serial_in, .ctl_port_serial_in,
        .voice_cap, .ctl_cap, .fwd_cap, .frame_done);

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    function automatic logic [7:0] rnd8();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr[7:0];
    endfunction : rnd8

    function automatic logic [7:0] get(input logic [255:0] v, input int ch);
        return v[255 - ch * 8 -: 8];
    endfunction : get

    function automatic void put(inout logic [255:0] v, input int ch,
                                input logic [7:0] b);
        v[255 - ch * 8 -: 8] = b;
    endfunction : put

    task automatic check_frame(input string name, input logic [255:0] e,
                               input logic [255:0] g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", name, e, g);
        end
    endtask : check_frame

    task automatic check_byte(input string name, input logic [7:0] e,
                              input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", name, e, g);
        end
    endtask : check_byte

    task automatic finish_test();
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test

    // ----
    // One mode: C write in first frame, second frame compared
    // ----
    task automatic run_cfg(input logic [2:0] m, input logic [7:0] cb,
                           input logic fast, input logic single);
        logic [255:0] vf, cf, ev, ec, ef;
        line_bytes_type lr;
        logic [7:0] st, dm, dr;
        logic tri_on, dfirst;
        tri_on = (m == MODE_TRISTATE);
        dfirst = (m == 3'h2);
        for (int i = 0; i < 32; i++) begin
            put(vf, i, rnd8());
            put(cf, i, single ? 8'hff : rnd8());
        end
        if (single) put(vf, 1, cb);
        else put(cf, dfirst ? 16 : 0, cb);
        lr = '{rnd8(), rnd8(), rnd8()};
        st = rnd8();
        @(posedge sys_clk);
        mode_select <= m;
        voice_frame <= vf;
        ctl_frame <= cf;
        line_rx <= lr;
        status_byte <= st;
        modem_line_bit <= st[0];
        modem_line_ctl_bit <= st[1];
        if (cb[7:4] == 4'hf) begin
            exp_ctrl = cb[3] ? 8'h08 : 8'h00;
            exp_diag = 8'h02;
        end else if (cb[1:0] == SEL_CONTROL) begin
            exp_ctrl = cb;
        end else if (cb[1:0] == SEL_DIAG) begin
            exp_diag = cb;
        end
        repeat (2) @(posedge frame_done);
        repeat (4) @(posedge sys_clk);
        dm = fast ? 8'hfc : 8'hfe;
        ev = {256{1'bz}};
        ec = ev;
        ef = '1;
        ef[255 - (single ? (fast ? 31 : 23) : 7)] = 1'b0;
        if (!tri_on && single) begin
            put(ev, 0, lr.d | dm);
            put(ev, 1, st);
            put(ev, 2, lr.b1);
            if (fast) put(ev, 3, lr.b2);
        end else if (!tri_on) begin
            put(ev, 0, lr.b1);
            if (fast) put(ev, 16, lr.b2);
            put(ec, dfirst ? 16 : 0, st);
            put(ec, dfirst ? 0 : 16, lr.d | dm);
        end
        check_frame("voice_out", ev, voice_cap);
        check_frame("ctl_out", ec, ctl_cap);
        check_frame("fwd_pulse", ef, fwd_cap);
        check_byte("control", exp_ctrl, line_control_byte);
        check_byte("diag", exp_diag, diag_byte);
        if (!tri_on) begin
            dr = single ? get(vf, 0) : get(cf, dfirst ? 0 : 16);
            check_byte("tx_d", dr | dm, line_tx.d);
            dr = get(vf, single ? 2 : 0);
            check_byte("tx_b1", dr, line_tx.b1);
            dr = get(vf, single ? 3 : 16);
            if (fast) check_byte("tx_b2", dr, line_tx.b2);
        end
    endtask : run_cfg

    always @(posedge sys_clk) begin
        cycles++;
        if (modem_bus_valid) begin
            check_byte("modem_bit", {7'h0, voice_frame[~u_partner.bit_num]},
                       {7'h0, modem_bus_bit});
            check_byte("modem_ctl_bit", {7'h0, ctl_frame[~u_partner.bit_num]},
                       {7'h0, modem_bus_ctl_bit});
        end
        if (cycles == 95000) begin
            n_fail++;
            finish_test();
        end
    end

    initial begin
        lfsr = 16'h0032;
        n_fail = 0;
        num_checks = 0;
        cycles = 0;
        rst = 1'b1;
        mode_select = 3'h0;
        voice_frame = '0;
        ctl_frame = '0;
        line_rx = '1;
        status_byte = 8'h00;
        modem_line_bit = 1'b0;
        modem_line_ctl_bit = 1'b0;
        exp_ctrl = CTRL_RESET;
        exp_diag = DIAG_RESET;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        check_byte("control", CTRL_RESET, line_control_byte);
        @(posedge frame_done);
        run_cfg(3'h0, 8'h08, 1'b1, 1'b0);
        run_cfg(3'h2, 8'h00, 1'b0, 1'b0);
        run_cfg(3'h3, 8'h06, 1'b0, 1'b1);
        run_cfg(3'h6, 8'h08, 1'b1, 1'b1);
        run_cfg(3'h4, 8'hf8, 1'b1, 1'b0);
        run_cfg(3'h7, 8'h08, 1'b1, 1'b0);
        @(posedge sys_clk);
        mode_select <= 3'h1;
        modem_line_bit <= 1'b0;
        modem_line_ctl_bit <= 1'b1;
        repeat (2) @(posedge frame_done);
        repeat (4) @(posedge sys_clk);
        check_frame("modem_voice", '0, voice_cap);
        check_frame("modem_ctl", '1, ctl_cap);
        check_byte("control", exp_ctrl, line_control_byte);
        finish_test();
    end
endmodule : tdm_port_channel_mapper_test
